// ### design/port_pkg.sv
// constants, types and states for the serial control port
// assumes a 20 MHz core clock and a separate spi slave link clock
// Contract
// - port works as master or slave, in spi or i2c protocol.
// - role is fixed from strap levels at reset release; outside holds them.
// - spi mode accepts a serial clock up to 25 MHz.
// - master spi serial clock never exceeds half the core clock; the slave link runs on the host clock.
// - a dedicated busy output tells the host the port cannot take more.
// - a dedicated request output flags a message waiting for the host.
// - straps are sampled on the third core clock edge after reset release to pick boot mode.
// - in spi slave mode the fourth audio input line becomes the port select.
package port_pkg;
   localparam int CORE_HZ        = 20_000_000;
   localparam int SPI_MAX_HZ     = 25_000_000;
   localparam int SPI_CORE_RATIO = 2;
   localparam int MASTER_SCK_HZ  = 2_500_000;
   localparam int I2C_SCL_HZ     = 400_000;
   // half periods of the master clock in core cycles
   localparam logic [4:0] SPI_HALF_CYC = 5'(CORE_HZ / (2 * MASTER_SCK_HZ));
   localparam logic [4:0] I2C_HALF_CYC = 5'(CORE_HZ / (2 * I2C_SCL_HZ));
   localparam logic [1:0] STRAP_WAIT   = 2'h2;
   localparam logic [2:0] LAST_BIT     = 3'h7;
   localparam logic [3:0] SPI_LAST     = 4'h7;
   localparam logic [3:0] I2C_LAST     = 4'h8;
   localparam logic [7:0] REPLY_RST    = 8'h00;
   localparam int         SYNC_W       = 7;
   localparam int SI_SDI = 0;
   localparam int SI_SDA = 1;
   localparam int SI_SCL = 2;
   localparam int SI_SEL = 3;
   localparam int SI_SPI = 4;
   localparam int SI_MST = 5;
   localparam int SI_TOG = 6;
   localparam logic [SYNC_W-1:0] SYNC_RST = 7'h0e;

   typedef struct packed {
      logic master;
      logic spi;
   } mode_t;
   localparam mode_t MODE_RST = '{master: 1'b0, spi: 1'b0};

   typedef enum logic [2:0] {
      M_IDLE  = 3'b000,
      M_START = 3'b001,
      M_BITS  = 3'b011,
      M_STOP  = 3'b010
   } mst_state_t;
endpackage

// ### design/serial_control_port.sv
// serial control port: spi or i2c, master or slave, role set by straps
// assumes straps static around reset release, pins asynchronous to clock_i
module serial_control_port (
   // clocks and reset
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic        sck_in_i,
   // straps
   input  wire logic        strap_master_i,
   input  wire logic        strap_spi_i,
   // spi pins
   input  wire logic        audio_in_line_four_i,
   input  wire logic        sdi_i,
   output logic             sck_o,
   output logic             sck_oe_o,
   output logic             select_o,
   output logic             select_oe_o,
   output logic             sdo_o,
   output logic             sdo_oe_o,
   // i2c pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   output logic             sda_o,
   output logic             sda_oe_o,
   // audio path
   output logic             audio_line_four_o,
   // dsp side
   input  wire logic [7:0]  tx_data_i,
   input  wire logic        tx_valid_i,
   output logic             tx_ready_o,
   output logic [7:0]       rx_data_o,
   output logic             rx_valid_o,
   input  wire logic        core_busy_i,
   input  wire logic        message_waiting_i,
   output logic             port_flow_hold_o,
   output logic             host_message_pending_o,
   output port_pkg::mode_t  mode_o
);
   import port_pkg::*;

   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_m_r;
   logic [SYNC_W-1:0] sync_s_r;
   logic              link_tog_r;
   logic              link_tog_nxt;
   logic [7:0]        link_byte_r;
   logic [7:0]        link_byte_nxt;
   logic [2:0]        link_cnt_r;
   logic [2:0]        link_cnt_nxt;
   logic [6:0]        link_sh_r;
   logic [6:0]        link_sh_nxt;
   logic              link_rst_b;

   assign sync_in = {link_tog_r, strap_master_i, strap_spi_i, audio_in_line_four_i,
                     scl_i, sda_i, sdi_i};

   // every pin and the link toggle pass two flops
   for (genvar g = 0; g < SYNC_W; g++)
   begin : g_sync
      always_ff @(posedge clock_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
         begin
            sync_m_r[g] <= SYNC_RST[g];
            sync_s_r[g] <= SYNC_RST[g];
         end
         else
         begin
            sync_m_r[g] <= sync_in[g];
            sync_s_r[g] <= sync_m_r[g];
         end
      end
   end

   // strap capture once the synchronisers hold real pin levels
   logic [1:0] strap_cnt_r;
   logic [1:0] strap_cnt_nxt;
   logic       strap_done_r;
   logic       strap_done_nxt;
   mode_t      mode_r;
   mode_t      mode_nxt;

   always_comb
   begin
      strap_cnt_nxt  = strap_cnt_r;
      strap_done_nxt = strap_done_r;
      mode_nxt       = mode_r;
      if (!strap_done_r)
      begin
         strap_cnt_nxt = strap_cnt_r + 2'h1;
         if (strap_cnt_r == STRAP_WAIT)
         begin
            strap_done_nxt = 1'b1;
            mode_nxt       = '{master: sync_s_r[SI_MST], spi: sync_s_r[SI_SPI]};
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         strap_cnt_r  <= 2'h0;
         strap_done_r <= 1'b0;
         mode_r       <= MODE_RST;
      end
      else
      begin
         strap_cnt_r  <= strap_cnt_nxt;
         strap_done_r <= strap_done_nxt;
         mode_r       <= mode_nxt;
      end
   end

   logic spi_slv;
   logic i2c_slv;
   assign spi_slv = strap_done_r & mode_r.spi & !mode_r.master;
   assign i2c_slv = strap_done_r & !mode_r.spi & !mode_r.master;

   // spi slave on the host clock; a high select clears the bit count
   assign link_rst_b = rst_b_i & ~audio_in_line_four_i;

   always_comb
   begin
      link_cnt_nxt  = link_cnt_r + 3'h1;
      link_sh_nxt   = {link_sh_r[5:0], sdi_i};
      link_byte_nxt = link_byte_r;
      link_tog_nxt  = link_tog_r;
      if (link_cnt_r == LAST_BIT)
      begin
         link_byte_nxt = {link_sh_r, sdi_i};
         link_tog_nxt  = ~link_tog_r;
      end
   end

   always_ff @(posedge sck_in_i or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         link_cnt_r <= 3'h0;
         link_sh_r  <= 7'h00;
      end
      else
      begin
         link_cnt_r <= link_cnt_nxt;
         link_sh_r  <= link_sh_nxt;
      end
   end

   // byte stays stable eight host clocks, well past the toggle crossing
   always_ff @(posedge sck_in_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         link_byte_r <= 8'h00;
         link_tog_r  <= 1'b0;
      end
      else
      begin
         link_byte_r <= link_byte_nxt;
         link_tog_r  <= link_tog_nxt;
      end
   end

   // i2c slave and spi/i2c master on the core clock
   logic       scl_d_r;
   logic       sda_d_r;
   logic       i2s_on_r;
   logic       i2s_on_nxt;
   logic [3:0] i2s_cnt_r;
   logic [3:0] i2s_cnt_nxt;
   logic [7:0] i2s_sh_r;
   logic [7:0] i2s_sh_nxt;
   logic       i2s_ack_r;
   logic       i2s_ack_nxt;
   logic       i2s_ev;
   logic       tog_seen_r;
   logic       spi_ev;
   logic       scl_rise;
   logic       scl_fall;

   mst_state_t st_r;
   mst_state_t st_nxt;
   logic [4:0] div_r;
   logic [4:0] div_nxt;
   logic       ph_r;
   logic       ph_nxt;
   logic [3:0] bit_r;
   logic [3:0] bit_nxt;
   logic [8:0] msh_r;
   logic [8:0] msh_nxt;
   logic [7:0] mrx_r;
   logic [7:0] mrx_nxt;
   logic       sck_r;
   logic       sck_nxt;
   logic       sda_m_r;
   logic       sda_m_nxt;
   logic       sel_r;
   logic       sel_nxt;
   logic       m_ev;
   logic       tick;
   logic       m_in;
   logic [4:0] half;

   logic [7:0] reply_r;
   logic [7:0] reply_nxt;
   logic [7:0] rx_data_nxt;
   logic       rx_valid_nxt;
   logic       hold_nxt;
   logic       pend_nxt;

   assign scl_rise = sync_s_r[SI_SCL] & !scl_d_r;
   assign scl_fall = !sync_s_r[SI_SCL] & scl_d_r;
   assign spi_ev   = spi_slv & (sync_s_r[SI_TOG] ^ tog_seen_r);
   assign half     = mode_r.spi ? SPI_HALF_CYC : I2C_HALF_CYC;
   assign tick     = (div_r == half - 5'h1);
   assign m_in     = mode_r.spi ? sync_s_r[SI_SDI] : sync_s_r[SI_SDA];
   assign tx_ready_o = strap_done_r & (mode_r.master ? (st_r == M_IDLE) : sync_s_r[SI_SEL]);

   always_comb
   begin
      i2s_on_nxt  = i2s_on_r;
      i2s_cnt_nxt = i2s_cnt_r;
      i2s_sh_nxt  = i2s_sh_r;
      i2s_ack_nxt = i2s_ack_r;
      i2s_ev      = 1'b0;
      if (i2c_slv && sync_s_r[SI_SCL] && scl_d_r && sda_d_r && !sync_s_r[SI_SDA])
      begin
         i2s_on_nxt  = 1'b1;
         i2s_cnt_nxt = 4'h0;
         i2s_ack_nxt = 1'b0;
      end
      else if (sync_s_r[SI_SCL] && scl_d_r && !sda_d_r && sync_s_r[SI_SDA])
         i2s_on_nxt = 1'b0;
      else if (i2c_slv && i2s_on_r && scl_rise && i2s_cnt_r < I2C_LAST)
      begin
         i2s_sh_nxt  = {i2s_sh_r[6:0], sync_s_r[SI_SDA]};
         i2s_cnt_nxt = i2s_cnt_r + 4'h1;
         i2s_ev      = (i2s_cnt_r == SPI_LAST);
      end
      else if (i2s_on_r && scl_fall)
      begin
         if (i2s_ack_r)
         begin
            i2s_ack_nxt = 1'b0;
            i2s_cnt_nxt = 4'h0;
         end
         else if (i2s_cnt_r == I2C_LAST)
            i2s_ack_nxt = 1'b1;
      end
   end

   // master: clock divided from the core clock, half period of four or more cycles
   always_comb
   begin
      st_nxt    = st_r;
      div_nxt   = (st_r == M_IDLE || tick) ? 5'h00 : div_r + 5'h01;
      ph_nxt    = ph_r;
      bit_nxt   = bit_r;
      msh_nxt   = msh_r;
      mrx_nxt   = mrx_r;
      sck_nxt   = sck_r;
      sda_m_nxt = sda_m_r;
      sel_nxt   = sel_r;
      m_ev      = 1'b0;
      case (st_r)
         M_IDLE:
            if (mode_r.master && tx_valid_i && tx_ready_o)
            begin
               st_nxt    = M_START;
               msh_nxt   = {tx_data_i, 1'b1};
               bit_nxt   = 4'h0;
               ph_nxt    = 1'b0;
               sel_nxt   = 1'b0;
               sda_m_nxt = 1'b0;
               // i2c start: data falls while the clock stays released
               sck_nxt   = !mode_r.spi;
            end
         M_START:
            if (tick)
            begin
               st_nxt  = M_BITS;
               sck_nxt = 1'b0;
            end
         M_BITS:
            if (tick && !ph_r)
            begin
               sck_nxt = 1'b1;
               ph_nxt  = 1'b1;
            end
            else if (tick)
            begin
               sck_nxt = 1'b0;
               ph_nxt  = 1'b0;
               msh_nxt = {msh_r[7:0], 1'b1};
               bit_nxt = bit_r + 4'h1;
               if (bit_r < I2C_LAST)
                  mrx_nxt = {mrx_r[6:0], m_in};
               if (bit_r == (mode_r.spi ? SPI_LAST : I2C_LAST))
               begin
                  st_nxt    = M_STOP;
                  sda_m_nxt = 1'b0;
               end
            end
         M_STOP:
            if (tick && !ph_r)
            begin
               // i2c stop: clock released before data rises; spi clock stays low
               sck_nxt = !mode_r.spi;
               ph_nxt  = 1'b1;
               sel_nxt = 1'b1;
            end
            else if (tick)
            begin
               sda_m_nxt = 1'b1;
               ph_nxt    = 1'b0;
               st_nxt    = M_IDLE;
               m_ev      = 1'b1;
            end
         default:
            st_nxt = M_IDLE;
      endcase
   end

   always_comb
   begin
      // reply only changes between frames; host waits on busy
      reply_nxt = (!mode_r.master && tx_valid_i && tx_ready_o) ? tx_data_i : reply_r;
      rx_valid_nxt = spi_ev | i2s_ev | m_ev;
      rx_data_nxt  = rx_data_o;
      if (spi_ev)
         rx_data_nxt = link_byte_r;
      else if (i2s_ev)
         rx_data_nxt = {i2s_sh_r[6:0], sync_s_r[SI_SDA]};
      else if (m_ev)
         rx_data_nxt = mrx_r;
      hold_nxt = core_busy_i | (st_r != M_IDLE) | !strap_done_r;
      pend_nxt = message_waiting_i;
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
         i2s_on_r   <= 1'b0;
         i2s_cnt_r  <= 4'h0;
         i2s_sh_r   <= 8'h00;
         i2s_ack_r  <= 1'b0;
         tog_seen_r <= 1'b0;
         st_r       <= M_IDLE;
         div_r      <= 5'h00;
         ph_r       <= 1'b0;
         bit_r      <= 4'h0;
         msh_r      <= 9'h1ff;
         mrx_r      <= 8'h00;
         sck_r      <= 1'b0;
         sda_m_r    <= 1'b1;
         sel_r      <= 1'b1;
         reply_r    <= REPLY_RST;
         rx_data_o  <= 8'h00;
         rx_valid_o <= 1'b0;
         port_flow_hold_o       <= 1'b1;
         host_message_pending_o <= 1'b0;
      end
      else
      begin
         scl_d_r    <= sync_s_r[SI_SCL];
         sda_d_r    <= sync_s_r[SI_SDA];
         i2s_on_r   <= i2s_on_nxt;
         i2s_cnt_r  <= i2s_cnt_nxt;
         i2s_sh_r   <= i2s_sh_nxt;
         i2s_ack_r  <= i2s_ack_nxt;
         tog_seen_r <= sync_s_r[SI_TOG];
         st_r       <= st_nxt;
         div_r      <= div_nxt;
         ph_r       <= ph_nxt;
         bit_r      <= bit_nxt;
         msh_r      <= msh_nxt;
         mrx_r      <= mrx_nxt;
         sck_r      <= sck_nxt;
         sda_m_r    <= sda_m_nxt;
         sel_r      <= sel_nxt;
         reply_r    <= reply_nxt;
         rx_data_o  <= rx_data_nxt;
         rx_valid_o <= rx_valid_nxt;
         port_flow_hold_o       <= hold_nxt;
         host_message_pending_o <= pend_nxt;
      end
   end

   logic m_on;
   logic sda_line;
   assign m_on     = strap_done_r & mode_r.master;
   assign sda_line = (st_r == M_BITS) ? msh_r[8] : sda_m_r;

   assign sck_o       = sck_r;
   assign sck_oe_o    = m_on & mode_r.spi;
   assign select_o    = sel_r;
   assign select_oe_o = m_on & mode_r.spi;
   // slave reply bit picked by the link count; flips just after the sampling edge
   assign sdo_o       = mode_r.master ? msh_r[8] : reply_r[3'(~link_cnt_r)];
   assign sdo_oe_o    = sck_oe_o | (spi_slv & !sync_s_r[SI_SEL]);
   assign scl_o       = 1'b0;
   assign scl_oe_o    = m_on & !mode_r.spi & (st_r != M_IDLE) & !sck_r;
   assign sda_o       = 1'b0;
   assign sda_oe_o    = (m_on & !mode_r.spi & (st_r != M_IDLE) & !sda_line) |
                        (i2c_slv & i2s_ack_r);
   assign audio_line_four_o = !mode_r.spi & sync_s_r[SI_SEL];
   assign mode_o      = mode_r;

   role_slave_a : assert property (@(posedge clock_i) disable iff (!rst_b_i)
      !mode_r.master |-> !sck_oe_o && !scl_oe_o && !select_oe_o)
      else $error("slave role drives a master line");

   role_locked_a : assert property (@(posedge clock_i) disable iff (!rst_b_i)
      strap_done_r |=> $stable(mode_r) && strap_done_r)
      else $error("role changed after strap capture");

   strap_sample_a : assert property (@(posedge clock_i) disable iff (!rst_b_i)
      $rose(strap_done_r) |-> mode_r.master == $past(sync_s_r[SI_MST], 1) &&
                              mode_r.spi == $past(sync_s_r[SI_SPI], 1))
      else $error("straps not taken at reset release");

   spi_high_a : assert property (@(posedge clock_i) disable iff (!rst_b_i)
      $rose(sck_r) && mode_r.spi |-> sck_r [*4] ##1 !sck_r)
      else $error("master spi clock high phase wrong length");

   clock_ratio_a : assert property (@(posedge clock_i) disable iff (!rst_b_i)
      $fell(sck_r) |-> !sck_r [*2])
      else $error("serial clock faster than half core clock");

   busy_flow_a : assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (core_busy_i || st_r != M_IDLE) |=> port_flow_hold_o)
      else $error("busy not shown while port is occupied");

   msg_pending_a : assert property (@(posedge clock_i) disable iff (!rst_b_i)
      message_waiting_i ##1 message_waiting_i |-> host_message_pending_o)
      else $error("waiting message not flagged to host");

   select_reuse_a : assert property (@(posedge clock_i) disable iff (!rst_b_i)
      strap_done_r && mode_r.spi |-> !audio_line_four_o)
      else $error("select line still forwarded to audio path");
endmodule

// ### bench/host_spi_model.sv
// host spi master model for the serial control port bench
// assumes mode 0, a free 12 ns tick, and sck standing still between frames
module host_spi_model (
   // tick
   input  wire logic base_clk_i,
   // spi lines
   input  wire logic miso_i,
   output logic      sck_o,
   output logic      sel_b_o,
   output logic      mosi_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // 120 ns sck, well under half the core clock
   localparam int HALF = 5;
   initial
   begin
      sck_o   = 1'b0;
      sel_b_o = 1'b1;
      mosi_o  = 1'b0;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge base_clk_i);
   endtask
   // short nbits tears the frame; gap gives a slow host
   task automatic xfer(input logic [7:0] tx, input int nbits, input int gap,
                       output logic [7:0] rx);
      rx = 8'h00;
      tick(1);
      sel_b_o = 1'b0;
      // select has to cross into the core before the first edge
      tick(16);
      for (int i = 7; i > 7 - nbits; i--)
      begin
         mosi_o = tx[i];
         tick(HALF + gap);
         sck_o = 1'b1;
         rx    = {rx[6:0], miso_i};
         tick(HALF);
         sck_o = 1'b0;
      end
      tick(HALF);
      sel_b_o = 1'b1;
      mosi_o  = ~mosi_o;
   endtask
endmodule

// ### bench/serial_control_port_tb_top.sv
// self-checking bench for the serial control port in all four strap roles
// assumes host_spi_model on the spi lines; i2c lines are pulled up here
module serial_control_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import port_pkg::*;
   logic       clock_i = 1'b0, link_clk = 1'b0, rst_b_i = 1'b0, audio_bit = 1'b0;
   logic       strap_master_i = 1'b0, strap_spi_i = 1'b0, cur_spi = 1'b0, loop_en = 1'b0;
   logic       tx_valid_i = 1'b0, core_busy_i = 1'b0, message_waiting_i = 1'b0;
   logic       scl_low = 1'b0, sda_low = 1'b0, miso_last = 1'b0;
   logic       h_sck, h_sel_b, h_mosi, miso_w, sdi_w, scl_w, sda_w, aud_w;
   logic       sck_o, sck_oe_o, select_o, select_oe_o, sdo_o, sdo_oe_o, scl_o, scl_oe_o;
   logic       sda_o, sda_oe_o, audio_line_four_o, tx_ready_o, rx_valid_o;
   logic       port_flow_hold_o, host_message_pending_o;
   logic [7:0] tx_data_i = 8'h00, rx_data_o, b, r, got;
   logic [7:0] exp_q[$];
   mode_t      mode_o;
   int         error_cnt = 0, samples_checked = 0, seed = 81, cyc = 0, n = 0;

   initial
      forever #25 clock_i = ~clock_i;
   initial
   begin
      #3.7;
      forever #6 link_clk = ~link_clk;
   end
   // a released data line shows the inverse of its last bit
   always @(sdo_o)
      if (sdo_oe_o)
         miso_last = sdo_o;
   assign miso_w = sdo_oe_o ? sdo_o : ~miso_last;
   assign sdi_w  = loop_en ? sdo_o : h_mosi;
   assign scl_w  = ~(scl_oe_o | scl_low);
   assign sda_w  = ~(sda_oe_o | sda_low);
   assign aud_w  = cur_spi ? h_sel_b : audio_bit;

   serial_control_port dut (
      .clock_i, .rst_b_i, .sck_in_i(h_sck), .strap_master_i, .strap_spi_i,
      .audio_in_line_four_i(aud_w), .sdi_i(sdi_w), .sck_o, .sck_oe_o, .select_o,
      .select_oe_o, .sdo_o, .sdo_oe_o, .scl_i(scl_w), .sda_i(sda_w), .scl_o, .scl_oe_o,
      .sda_o, .sda_oe_o, .audio_line_four_o, .tx_data_i, .tx_valid_i, .tx_ready_o,
      .rx_data_o, .rx_valid_o, .core_busy_i, .message_waiting_i, .port_flow_hold_o,
      .host_message_pending_o, .mode_o);
   host_spi_model u_host (.base_clk_i(link_clk), .miso_i(miso_w), .sck_o(h_sck),
                          .sel_b_o(h_sel_b), .mosi_o(h_mosi));

   task automatic wn(input int k);
      repeat (k) @(negedge clock_i);
   endtask
   task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
      samples_checked++;
      if (got_v !== exp_v)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // valid stays up until the edge that takes it
   task automatic send_tx(input logic [7:0] d);
      tx_data_i = d;
      tx_valid_i = 1'b1;
      for (n = 0; n < 2000 && tx_ready_o !== 1'b1; n++)
         wn(1);
      wn(1);
   endtask
   task automatic drain();
      for (n = 0; n < 3000 && exp_q.size() != 0; n++)
         wn(1);
      chk(8'(exp_q.size()), 8'h00);
   endtask
   // straps flip after capture; the role must not follow
   task automatic restart(input logic m, input logic s);
      wn(1);
      rst_b_i = 1'b0;
      strap_master_i = m;
      strap_spi_i = s;
      cur_spi = s;
      loop_en = m;
      wn(8);
      chk(8'(port_flow_hold_o), 8'h01);
      rst_b_i = 1'b1;
      wn(6);
      chk(8'(mode_o), 8'({m, s}));
      strap_master_i = ~m;
      strap_spi_i = ~s;
      wn(3);
      chk(8'(mode_o), 8'({m, s}));
   endtask
   task automatic i2c_byte(input logic [7:0] d);
      exp_q.push_back(d);
      sda_low = 1'b1;
      for (int i = 7; i >= -1; i--)
      begin
         wn(10);
         scl_low = 1'b1;
         wn(5);
         sda_low = (i < 0) ? 1'b0 : ~d[i];
         wn(5);
         scl_low = 1'b0;
         wn(3);
         if (i < 0)
            chk(8'(sda_oe_o), 8'h01);
      end
      wn(7);
      scl_low = 1'b1;
      sda_low = 1'b1;
      wn(5);
      scl_low = 1'b0;
      wn(5);
      sda_low = 1'b0;
   endtask

   always @(negedge clock_i)
      if (rx_valid_o === 1'b1)
         chk(rx_data_o, (exp_q.size() != 0) ? exp_q.pop_front() : ~rx_data_o);
   always @(posedge clock_i)
      if (++cyc == 20000)
      begin
         error_cnt++;
         conclude();
      end

   initial
   begin
      restart(1'b0, 1'b0);
      repeat (200)
      begin
         core_busy_i = 1'($random(seed));
         message_waiting_i = 1'($random(seed));
         wn(1);
         chk(8'(port_flow_hold_o), 8'(core_busy_i));
         chk(8'(host_message_pending_o), 8'(message_waiting_i));
      end
      core_busy_i = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         audio_bit = 1'($random(seed));
         wn(4);
         chk(8'(audio_line_four_o), 8'(audio_bit));
      end
      i2c_byte(8'($random(seed)));
      $display("done: i2c slave, busy, request, audio");
      restart(1'b0, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         b = 8'($random(seed));
         r = 8'($random(seed));
         core_busy_i = (k == 1);
         wn(4);
         chk(8'(port_flow_hold_o), 8'(k == 1));
         core_busy_i = 1'b0;
         for (n = 0; n < 100 && port_flow_hold_o !== 1'b0; n++)
            wn(1);
         send_tx(r);
         tx_valid_i = 1'b0;
         if (k == 2)
            u_host.xfer(~b, 4, 0, got);
         exp_q.push_back(b);
         u_host.xfer(b, 8, 3 * k, got);
         chk(got, r);
         chk(8'(audio_line_four_o), 8'h00);
         drain();
      end
      $display("done: spi slave");
      restart(1'b1, 1'b1);
      for (int k = 0; k < 3; k++)
      begin
         b = 8'($random(seed));
         exp_q.push_back(b);
         send_tx(b);
      end
      tx_valid_i = 1'b0;
      wn(1);
      chk({5'h00, port_flow_hold_o, select_o, sck_oe_o}, 8'h05);
      drain();
      $display("done: spi master");
      restart(1'b1, 1'b0);
      exp_q.push_back(8'ha5);
      send_tx(8'ha5);
      tx_valid_i = 1'b0;
      chk({6'h00, scl_w, sda_w}, 8'h02);
      drain();
      $display("done: i2c master");
      conclude();
   end
endmodule
